/* File: tad_pkg.sv */
package tad_pkg;
  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned ROM_DELAY_NS  = 160;
  localparam int unsigned ROM_DELAY_CYC =
    (ROM_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CPU_DIV       = 6;
  localparam int unsigned RX20_DIV      = 9;
  localparam int unsigned M2X_DIV       = 10;

  // -----------------------------------------------------------------
  // processor address map
  // -----------------------------------------------------------------
  localparam logic [1:0]  ROM_TAG       = 2'h3;
  localparam logic [4:0]  IO_TAG        = 5'h08;
  localparam logic [4:0]  RAM_TAG       = 5'h00;
  localparam int unsigned ROM_TAG_LSB   = 14;
  localparam int unsigned BLK_TAG_LSB   = 11;
  localparam int unsigned SECT_LSB      = 8;
  localparam int unsigned RAM_AW        = 11;
  localparam int unsigned N_SECT        = 8;

  // -----------------------------------------------------------------
  // shared ram locations
  // -----------------------------------------------------------------
  localparam logic [6:0]  CSR_BASE_HI   = 7'h01;
  localparam logic [10:0] DMA_OUT_LO    = 11'h038;
  localparam logic [10:0] DMA_OUT_HI    = 11'h039;
  localparam logic [10:0] DMA_IN_LO     = 11'h03C;
  localparam logic [10:0] DMA_IN_HI     = 11'h03D;
  localparam logic [10:0] CSR_IE_ADDR   = 11'h010;
  localparam logic [2:0]  CSR_IE_WORD   = 3'h0;
  localparam int unsigned CSR_IE_BIT    = 6;

  // -----------------------------------------------------------------
  // host interrupt request section
  // -----------------------------------------------------------------
  localparam logic [2:0]  IRQ_SECT      = 3'h7;
  localparam int unsigned IRQ_A_BIT     = 0;
  localparam int unsigned IRQ_B_BIT     = 1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SYNC,
    ST_XFER,
    ST_DONE,
    ST_HOLD
  } csr_state_t;
endpackage

/* File: clk_div.sv */
module clk_div #(
  parameter int unsigned DIVISOR = 2
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rstn,
  // count enable
  input  wire logic i_tick,
  // divided outputs
  output logic      o_tc,
  output logic      o_sq
);
  localparam int unsigned CW = $clog2(DIVISOR);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tc;
    logic          sq;
  } div_t;

  div_t s;
  div_t next_s;

  always_comb begin
    next_s    = s;
    next_s.tc = 1'b0;
    if (i_tick) begin
      if (s.cnt == CW'(DIVISOR - 1)) begin
        next_s.cnt = '0;
        next_s.tc  = 1'b1;
        next_s.sq  = ~s.sq;
      end else begin
        next_s.cnt = s.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_tc = s.tc;
  assign o_sq = s.sq;
endmodule

/* File: timing_decode.sv */
module timing_decode (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // 20 MHz source, one-cycle pulse per source period
  input  wire logic        i_osc_tick,
  // embedded processor bus
  input  wire logic [15:0] i_cpu_addr,
  input  wire logic        i_cpu_rw,
  input  wire logic [7:0]  i_cpu_wdata,
  input  wire logic        i_cpu_sync,
  // host csr port
  input  wire logic        i_csr_req,
  input  wire logic [2:0]  i_csr_index,
  input  wire logic        i_csr_write,
  input  wire logic        i_csr_byte_lo,
  input  wire logic        i_csr_byte_hi,
  input  wire logic [15:0] i_csr_wdata,
  input  wire logic        i_irq_ack_a,
  input  wire logic        i_irq_ack_b,
  // ram data back
  input  wire logic [15:0] i_ram_rdata,
  // clocks
  output logic             o_cpu_phi1,
  output logic             o_cpu_phi2,
  output logic             o_rx20_clk,
  output logic             o_modem2x_clk,
  output logic             o_rom_strobe,
  // processor control
  output logic             o_cpu_halt,
  output logic             o_opcode_fetch,
  // block and io selects
  output logic             o_sel_rom,
  output logic             o_sel_io,
  output logic             o_sel_ram,
  output logic [7:0]       o_io_sect,
  // ram control
  output logic [10:0]      o_ram_addr,
  output logic             o_ram_en_even,
  output logic             o_ram_en_odd,
  output logic             o_ram_we,
  output logic [15:0]      o_ram_wdata,
  output logic             o_ram_wide,
  output logic             o_ram_cpu_off,
  // host csr answer
  output logic             o_csr_ack,
  output logic [15:0]      o_csr_rdata,
  // dma addresses
  output logic [15:0]      o_dma_in_addr,
  output logic [15:0]      o_dma_out_addr,
  // host interrupts
  output logic             o_irq_a,
  output logic             o_irq_b
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                                  sq_d;
    logic                                  phi1;
    logic                                  phi2;
    logic [tad_pkg::ROM_DELAY_CYC-1:0]     rom_dly;
    tad_pkg::csr_state_t                   st;
    logic                                  halt;
    logic                                  fetch;
    logic                                  sel_rom;
    logic                                  sel_io;
    logic                                  sel_ram;
    logic [tad_pkg::N_SECT-1:0]            sect;
    logic [tad_pkg::RAM_AW-1:0]            ram_addr;
    logic                                  en_even;
    logic                                  en_odd;
    logic                                  we;
    logic [15:0]                           wdata;
    logic                                  wide;
    logic                                  cpu_off;
    logic                                  ack;
    logic [15:0]                           rdata;
    logic [15:0]                           dma_in;
    logic [15:0]                           dma_out;
    logic                                  ie;
    logic                                  req_a;
    logic                                  req_b;
    logic                                  irq_a;
    logic                                  irq_b;
  } td_t;

  td_t  s;
  td_t  next_s;
  logic cpu_sq;
  logic rx20_tc;
  logic rx20_sq;
  logic m2x_sq;

  // ---------------------------------------------------------------
  // clock dividers
  // ---------------------------------------------------------------
  clk_div #(.DIVISOR(tad_pkg::CPU_DIV)) u_cpu_div (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_tick (i_osc_tick),
    .o_tc   (),
    .o_sq   (cpu_sq)
  );

  clk_div #(.DIVISOR(tad_pkg::RX20_DIV)) u_rx20_div (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_tick (i_osc_tick),
    .o_tc   (rx20_tc),
    .o_sq   (rx20_sq)
  );

  // five receive periods per half cycle of the 2x clock
  clk_div #(.DIVISOR(tad_pkg::M2X_DIV)) u_m2x_div (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_tick (rx20_tc),
    .o_tc   (),
    .o_sq   (m2x_sq)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic       wr_strobe;
  logic       cpu_ram;
  logic       cpu_io;
  logic       host_xfer;
  logic [2:0] cpu_sect;

  always_comb begin
    next_s    = s;
    cpu_sect  = i_cpu_addr[tad_pkg::SECT_LSB +: 3];
    cpu_ram   = i_cpu_addr[15:tad_pkg::BLK_TAG_LSB] == tad_pkg::RAM_TAG;
    cpu_io    = i_cpu_addr[15:tad_pkg::BLK_TAG_LSB] == tad_pkg::IO_TAG;
    host_xfer = s.st == tad_pkg::ST_XFER;

    // one idle clk cycle of gap at each edge keeps phases apart
    next_s.sq_d = cpu_sq;
    next_s.phi1 = ~cpu_sq & ~s.sq_d;
    next_s.phi2 = cpu_sq & s.sq_d;
    next_s.rom_dly = {s.rom_dly[tad_pkg::ROM_DELAY_CYC-2:0], s.phi2};

    // phase two except its last cycle: processor data is valid
    wr_strobe = s.phi2 & cpu_sq & ~s.halt & ~i_cpu_rw;

    // host csr sequencer
    unique case (s.st)
      tad_pkg::ST_IDLE: begin
        if (i_csr_req) begin
          next_s.st      = tad_pkg::ST_SYNC;
          next_s.halt    = 1'b1;
          next_s.cpu_off = 1'b1;
        end
      end
      tad_pkg::ST_SYNC: begin
        // wait for phase one so no processor transfer is cut short
        if (s.phi1) begin
          next_s.st = tad_pkg::ST_XFER;
        end
      end
      tad_pkg::ST_XFER: begin
        next_s.st = tad_pkg::ST_DONE;
      end
      tad_pkg::ST_DONE: begin
        next_s.rdata = i_ram_rdata;
        next_s.ack   = 1'b1;
        next_s.st    = tad_pkg::ST_HOLD;
      end
      tad_pkg::ST_HOLD: begin
        if (!i_csr_req) begin
          next_s.ack     = 1'b0;
          next_s.halt    = 1'b0;
          next_s.cpu_off = 1'b0;
          next_s.st      = tad_pkg::ST_IDLE;
        end
      end
    endcase

    // address steering and block decode
    if (next_s.st == tad_pkg::ST_XFER) begin
      // host owns the bus; 16-bit word built from even and odd bytes
      next_s.ram_addr = {tad_pkg::CSR_BASE_HI, i_csr_index, 1'b0};
      next_s.en_even  = i_csr_byte_lo | ~i_csr_write;
      next_s.en_odd   = i_csr_byte_hi | ~i_csr_write;
      next_s.we       = i_csr_write;
      next_s.wdata    = i_csr_wdata;
      next_s.wide     = 1'b1;
      next_s.sel_rom  = 1'b0;
      next_s.sel_io   = 1'b0;
      next_s.sel_ram  = 1'b1;
      next_s.sect     = '0;
    end else begin
      next_s.ram_addr = i_cpu_addr[tad_pkg::RAM_AW-1:0];
      next_s.sel_rom  = ~s.halt &
        (i_cpu_addr[15:tad_pkg::ROM_TAG_LSB] == tad_pkg::ROM_TAG);
      next_s.sel_io   = ~s.halt & cpu_io;
      next_s.sel_ram  = ~s.halt & cpu_ram;
      next_s.en_even  = ~s.halt & cpu_ram & ~i_cpu_addr[0];
      next_s.en_odd   = ~s.halt & cpu_ram & i_cpu_addr[0];
      next_s.we       = cpu_ram & wr_strobe;
      next_s.wdata    = {i_cpu_wdata, i_cpu_wdata};
      next_s.wide     = 1'b0;
      next_s.sect     = '0;
      if (!s.halt && cpu_io) begin
        next_s.sect[cpu_sect] = 1'b1;
      end
    end

    next_s.fetch = i_cpu_sync & ~s.halt;

    // dma address registers track writes to their ram bytes
    if (wr_strobe && cpu_ram) begin
      unique case (i_cpu_addr[tad_pkg::RAM_AW-1:0])
        tad_pkg::DMA_OUT_LO: next_s.dma_out[7:0]  = i_cpu_wdata;
        tad_pkg::DMA_OUT_HI: next_s.dma_out[15:8] = i_cpu_wdata;
        tad_pkg::DMA_IN_LO:  next_s.dma_in[7:0]   = i_cpu_wdata;
        tad_pkg::DMA_IN_HI:  next_s.dma_in[15:8]  = i_cpu_wdata;
        tad_pkg::CSR_IE_ADDR: next_s.ie = i_cpu_wdata[tad_pkg::CSR_IE_BIT];
        default: ;
      endcase
    end

    // host interrupt enable follows the host's own csr write
    if (host_xfer && i_csr_write && i_csr_byte_lo &&
        i_csr_index == tad_pkg::CSR_IE_WORD) begin
      next_s.ie = i_csr_wdata[tad_pkg::CSR_IE_BIT];
    end

    // request bits: acknowledge clears, a new request in the same cycle wins
    if (i_irq_ack_a) begin
      next_s.req_a = 1'b0;
    end
    if (i_irq_ack_b) begin
      next_s.req_b = 1'b0;
    end
    if (wr_strobe && cpu_io && cpu_sect == tad_pkg::IRQ_SECT) begin
      if (i_cpu_wdata[tad_pkg::IRQ_A_BIT]) begin
        next_s.req_a = 1'b1;
      end
      if (i_cpu_wdata[tad_pkg::IRQ_B_BIT]) begin
        next_s.req_b = 1'b1;
      end
    end
    next_s.irq_a = s.req_a & s.ie;
    next_s.irq_b = s.req_b & s.ie;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s    <= '0;
      s.st <= tad_pkg::ST_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_cpu_phi1     = s.phi1;
  assign o_cpu_phi2     = s.phi2;
  assign o_rx20_clk     = rx20_sq;
  assign o_modem2x_clk  = m2x_sq;
  assign o_rom_strobe   = s.rom_dly[tad_pkg::ROM_DELAY_CYC-1];
  assign o_cpu_halt     = s.halt;
  assign o_opcode_fetch = s.fetch;
  assign o_sel_rom      = s.sel_rom;
  assign o_sel_io       = s.sel_io;
  assign o_sel_ram      = s.sel_ram;
  assign o_io_sect      = s.sect;
  assign o_ram_addr     = s.ram_addr;
  assign o_ram_en_even  = s.en_even;
  assign o_ram_en_odd   = s.en_odd;
  assign o_ram_we       = s.we;
  assign o_ram_wdata    = s.wdata;
  assign o_ram_wide     = s.wide;
  assign o_ram_cpu_off  = s.cpu_off;
  assign o_csr_ack      = s.ack;
  assign o_csr_rdata    = s.rdata;
  assign o_dma_in_addr  = s.dma_in;
  assign o_dma_out_addr = s.dma_out;
  assign o_irq_a        = s.irq_a;
  assign o_irq_b        = s.irq_b;
endmodule

/* File: tad_monitor.sv */
module tad_monitor (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // watched inputs
  input  wire logic        i_csr_req,
  input  wire logic [15:0] i_cpu_addr,
  input  wire logic        i_cpu_sync,
  // watched outputs
  input  wire logic        o_cpu_phi1,
  input  wire logic        o_cpu_phi2,
  input  wire logic        o_rom_strobe,
  input  wire logic        o_cpu_halt,
  input  wire logic        o_ram_cpu_off,
  input  wire logic        o_opcode_fetch,
  input  wire logic        o_sel_rom,
  input  wire logic        o_sel_io,
  input  wire logic        o_sel_ram,
  input  wire logic [7:0]  o_io_sect,
  input  wire logic [10:0] o_ram_addr,
  input  wire logic        o_ram_wide,
  input  wire logic        o_csr_ack,
  input  wire logic        o_irq_a
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cyc;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  // delay line history is only valid once it has refilled after reset
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) cyc <= 5'h00;
    else if (cyc != 5'h1F) cyc <= cyc + 5'h01;
  end

  // -----------------------------------------------------------------
  // properties
  // -----------------------------------------------------------------
  a_phase_no_overlap: assert property (!(o_cpu_phi1 && o_cpu_phi2))
    else $error("processor phases overlap");
  a_rom_strobe_delay: assert property (cyc > 5'h15
    |-> o_rom_strobe == $past(o_cpu_phi2, 20))
    else $error("rom strobe not phase two delayed");
  a_host_halts_cpu: assert property ($rose(i_csr_req) && !o_csr_ack |=> o_cpu_halt)
    else $error("host access did not halt processor");
  // worst case: phase one has just fallen and stays low for 37 cycles
  a_ack_wait_bound: assert property ($rose(i_csr_req) |-> ##[4:41] o_csr_ack)
    else $error("host access not answered in time");
  a_halt_release: assert property (!i_csr_req && $past(i_csr_req) && o_csr_ack
    |=> !o_csr_ack && !o_cpu_halt)
    else $error("halt not released after access");
  a_cut_while_halt: assert property (o_cpu_halt |-> o_ram_cpu_off)
    else $error("ram still on processor bus while halted");
  a_fetch_follows: assert property (!o_cpu_halt && !$past(o_cpu_halt)
    |-> o_opcode_fetch == $past(i_cpu_sync))
    else $error("opcode fetch flag wrong");
  a_io_section_sel: assert property (o_sel_io
    |-> o_io_sect == (8'h01 << $past(i_cpu_addr[10:8])))
    else $error("io section select wrong");
  a_rom_block_sel: assert property (!o_cpu_halt && !$past(o_cpu_halt)
    |-> o_sel_rom == ($past(i_cpu_addr[15:14]) == 2'h3))
    else $error("rom block select wrong");
  a_wide_host_only: assert property (o_ram_wide
    |-> o_cpu_halt && o_sel_ram && o_ram_addr[10:4] == 7'h01)
    else $error("wide ram access outside host csr window");

  c_host_ack: cover property (o_csr_ack);
  c_io_sel:   cover property (o_sel_io);
  c_irq_a:    cover property (o_irq_a);
endmodule

/* File: tad_ram_model.sv */
module tad_ram_model (
  // clock
  input  wire logic        i_clk,
  // ram control from the block
  input  wire logic [10:0] i_addr,
  input  wire logic        i_en_even,
  input  wire logic        i_en_odd,
  input  wire logic        i_we,
  input  wire logic [15:0] i_wdata,
  // read data {odd,even}
  output logic      [15:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [1024];

  initial begin
    o_rdata = 16'h5A5A;
    for (int i = 0; i < 1024; i++) mem[i] = 16'h0000;
  end

  // data holds one cycle only; afterwards it flips so stale reads show
  always @(posedge i_clk) begin
    if (i_we && i_en_even) mem[i_addr[10:1]][7:0] <= i_wdata[7:0];
    if (i_we && i_en_odd) mem[i_addr[10:1]][15:8] <= i_wdata[15:8];
    if (!i_we && (i_en_even || i_en_odd)) o_rdata <= mem[i_addr[10:1]];
    else o_rdata <= ~o_rdata;
  end
endmodule

/* File: controller_timing_and_address_decode_bench.sv */
module controller_timing_and_address_decode_bench;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end

  logic        i_clk, i_rstn, i_osc_tick, i_cpu_rw, i_cpu_sync, i_csr_req, i_csr_write;
  logic        i_csr_byte_lo, i_csr_byte_hi, i_irq_ack_a, i_irq_ack_b;
  logic [15:0] i_cpu_addr, i_csr_wdata, i_ram_rdata, o_csr_rdata, o_ram_wdata;
  logic [15:0] o_dma_in_addr, o_dma_out_addr;
  logic [7:0]  i_cpu_wdata, o_io_sect;
  logic [2:0]  i_csr_index;
  logic [10:0] o_ram_addr;
  logic        o_cpu_phi1, o_cpu_phi2, o_rx20_clk, o_modem2x_clk, o_rom_strobe, o_cpu_halt;
  logic        o_opcode_fetch, o_sel_rom, o_sel_io, o_sel_ram, o_ram_en_even, o_ram_en_odd;
  logic        o_ram_we, o_ram_wide, o_ram_cpu_off, o_csr_ack, o_irq_a, o_irq_b;
  int          mismatches, checks, tk, n, h, l;
  // address in [27:12], {rom,io,ram} in [10:8], one-hot section in [7:0]
  logic [27:0] dec [6] = '{28'hC3A_5400, 28'h453_7220, 28'h45F_F220, 28'h07F_F100,
                           28'h400_0201, 28'h200_0000};

  timing_decode DUT (.*);
  tad_ram_model ram (.i_clk(i_clk), .i_addr(o_ram_addr), .i_en_even(o_ram_en_even),
    .i_en_odd(o_ram_en_odd), .i_we(o_ram_we), .i_wdata(o_ram_wdata), .o_rdata(i_ram_rdata));

  initial begin
    i_clk = 0;
    forever #4 i_clk = ~i_clk;
  end
  // fixed six-cycle spacing keeps every divided period a whole clk count
  always @(negedge i_clk) begin
    tk <= (tk == 5) ? 0 : tk + 1;
    i_osc_tick <= (tk == 5);
  end

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return o_cpu_phi2;
      1: return o_rx20_clk;
      2: return o_modem2x_clk;
      default: return o_csr_ack;
    endcase
  endfunction
  task automatic wait_on(input int k, input logic lvl, output int c);
    c = 0;
    while (pick(k) !== lvl) begin
      @(negedge i_clk);
      c++;
      if (c > 2000) begin
        mismatches++;
        $display("[FAIL] wait %0d exp %h got timeout", k, lvl);
        end_sim();
      end
    end
  endtask
  task automatic host(input logic w, input logic [2:0] x, input logic lo, input logic hi,
                      input logic [15:0] d);
    @(negedge i_clk);
    {i_csr_req, i_csr_write, i_csr_index, i_csr_byte_lo, i_csr_byte_hi} = {1'b1, w, x, lo, hi};
    i_csr_wdata = d;
    wait_on(3, 1, n);
    i_csr_req = 0;
    wait_on(3, 0, n);
  endtask
  task automatic cpu_write(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_clk);
    wait_on(0, 0, n);
    {i_cpu_addr, i_cpu_wdata, i_cpu_rw} = {a, d, 1'b0};
    wait_on(0, 1, n);
    wait_on(0, 0, n);
    {i_cpu_addr, i_cpu_rw} = {16'h2000, 1'b1};
  endtask

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_clocks;
    int per [3] = '{72, 108, 1080};
    for (int k = 0; k < 3; k++) begin
      wait_on(k, 0, n);
      wait_on(k, 1, n);
      wait_on(k, 0, h);
      wait_on(k, 1, l);
      // phase two gives up one clk to the non-overlap gap
      `CHK("high time", per[k] / 2 - (k == 0 ? 1 : 0), h)
      `CHK("period", per[k], h + l)
    end
  endtask
  task automatic t_csr;
    host(1, 3'h3, 1, 1, 16'hA5C3);
    host(0, 3'h3, 1, 1, 16'h0000);
    `CHK("csr word", 16'hA5C3, o_csr_rdata)
    host(1, 3'h3, 0, 1, 16'h12FF);
    host(0, 3'h3, 1, 1, 16'h0000);
    `CHK("csr hi lane", 16'h12C3, o_csr_rdata)
  endtask
  task automatic t_decode;
    foreach (dec[i]) begin
      @(negedge i_clk);
      {i_cpu_addr, i_cpu_sync} = {dec[i][27:12], 1'b1};
      repeat (2) @(negedge i_clk);
      `CHK("blocks", dec[i][10:8], {o_sel_rom, o_sel_io, o_sel_ram})
      if (dec[i][9]) `CHK("section", dec[i][7:0], o_io_sect)
      `CHK("fetch", 1'b1, o_opcode_fetch)
    end
    i_cpu_sync = 0;
  endtask
  task automatic t_dma;
    cpu_write(16'h0038, 8'h34);
    cpu_write(16'h0039, 8'h12);
    cpu_write(16'h003D, 8'hAB);
    cpu_write(16'h003C, 8'hCD);
    @(negedge i_clk);
    `CHK("dma out", 16'h1234, o_dma_out_addr)
    `CHK("dma in", 16'hABCD, o_dma_in_addr)
  endtask
  task automatic t_irq;
    cpu_write(16'h0010, 8'h40);
    cpu_write(16'h4700, 8'h03);
    repeat (2) @(negedge i_clk);
    `CHK("irq both", 2'b11, {o_irq_a, o_irq_b})
    i_irq_ack_a = 1;
    @(negedge i_clk);
    i_irq_ack_a = 0;
    repeat (2) @(negedge i_clk);
    `CHK("irq after ack", 2'b01, {o_irq_a, o_irq_b})
    i_irq_ack_b = 1;
    @(negedge i_clk);
    i_irq_ack_b = 0;
    cpu_write(16'h0010, 8'h00);
    cpu_write(16'h4780, 8'h03);
    repeat (2) @(negedge i_clk);
    `CHK("irq disabled", 2'b00, {o_irq_a, o_irq_b})
    host(1, 3'h0, 1, 0, 16'h0040);
    repeat (2) @(negedge i_clk);
    `CHK("irq host enable", 2'b11, {o_irq_a, o_irq_b})
  endtask

  initial begin
    {i_rstn, i_cpu_sync, i_csr_req, i_csr_write, i_irq_ack_a, i_irq_ack_b} = '0;
    {i_cpu_rw, i_csr_byte_lo, i_csr_byte_hi, i_cpu_addr, i_cpu_wdata} = {3'h7, 24'h0};
    {i_csr_index, i_csr_wdata} = '0;
    repeat (10) @(negedge i_clk);
    i_rstn = 1;
    t_clocks();
    t_csr();
    t_decode();
    t_dma();
    t_irq();
    i_rstn = 0;
    repeat (3) @(negedge i_clk);
    `CHK("reset clocks", 4'h0, {o_cpu_phi2, o_rx20_clk, o_modem2x_clk, o_cpu_halt})
    i_rstn = 1;
    t_csr();
    end_sim();
  end
endmodule

bind timing_decode tad_monitor mon (.*);
